// file: verilog/rff_pkg.sv
// Purpose: constants for the receive frame filter
// Assumes: axi4-lite register access, 32-bit data
// Notes:   register offsets are byte addresses
package rff_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] RFF_OFS_CTRL     = 8'h00;
  localparam logic [7:0] RFF_OFS_STA_LO   = 8'h04;
  localparam logic [7:0] RFF_OFS_STA_HI   = 8'h08;
  localparam logic [7:0] RFF_OFS_HASH_LO  = 8'h0c;
  localparam logic [7:0] RFF_OFS_HASH_HI  = 8'h10;
  localparam logic [7:0] RFF_OFS_MASK_LO  = 8'h14;
  localparam logic [7:0] RFF_OFS_MASK_HI  = 8'h18;
  localparam logic [7:0] RFF_OFS_PAT      = 8'h1c;
  localparam logic [7:0] RFF_OFS_STATUS   = 8'h20;
  // ---------------------------------------------------------------
  // control bits and reset value
  // ---------------------------------------------------------------
  localparam int RFF_BIT_BCAST  = 0;
  localparam int RFF_BIT_MCAST  = 1;
  localparam int RFF_BIT_HASH   = 2;
  localparam int RFF_BIT_WAKE   = 3;
  localparam int RFF_BIT_PAT    = 4;
  localparam int RFF_BIT_FCS    = 5;
  localparam int RFF_BIT_AND    = 6;
  localparam int RFF_BIT_UCAST  = 7;
  localparam logic [7:0] RFF_CTRL_RST = 8'ha1;
  // ---------------------------------------------------------------
  // frame constants and bus response codes
  // ---------------------------------------------------------------
  localparam int          RFF_WIN_LEN   = 64;
  localparam logic [31:0] RFF_CRC_POLY  = 32'h04c11db7;
  localparam int          RFF_HASH_LSB  = 23;
  localparam int          RFF_DA_LEN    = 6;
  localparam int          RFF_WAKE_SYNC = 6;
  localparam int          RFF_WAKE_REPS = 16;
  localparam logic [2:0]  RFF_RESP_OK   = 3'h0;
  localparam logic [1:0]  RFF_RESP_ERR  = 2'h2;
endpackage : rff_pkg

// file: verilog/rff_filter.sv
// Purpose: receive frame acceptance filter with axi4-lite registers
// Assumes: one frame byte per valid cycle, destination through fcs, fcs_ok with last
// Notes:   one verdict pulse per frame after the last byte
// Functional notes
// RQ1: and mode needs all enabled filters
// RQ2: or mode needs any enabled filter
// RQ3: fcs check bit discards bad crc
// RQ4: unicast filter matches station address
// RQ5: multicast filter checks group bit
// RQ6: broadcast filter matches all ones address
// RQ7: hash filter joins the decision
// RQ8: wake-up filter joins the decision
// RQ9: pattern filter joins the decision
// RQ10: pattern checksum equals expected sum
// RQ11: window offset counts from destination start
// RQ12: mask bit selects each window byte
// RQ13: masked bytes are skipped, not zeroed
// RQ14: window past frame end fails pattern
// RQ15: software keeps pattern offset even
// RQ16: wake-up sync then sixteen address copies
// RQ17: wake-up also needs unicast address match
// RQ18: big-endian one's complement checksum
// RQ19: crc-32 hash index bits 28:23
// RQ20: station address compared byte for byte
// RQ21: one verdict per frame after fcs
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rff_filter
  import rff_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_fcs_ok,
  output logic             verdict_valid,
  output logic             verdict_accept
);
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_ff;
  logic [47:0] sta_ff;
  logic [63:0] hash_ff;
  logic [63:0] mask_ff;
  logic [15:0] poff_ff;
  logic [15:0] psum_ff;
  logic [7:0]  last_ff;      // last verdict and per-filter hits
  logic        aw_got_ff, w_got_ff;
  logic [7:0]  aw_ff;
  logic [31:0] wd_ff;
  logic [3:0]  ws_ff;

  // byte lane merge, used for every writable word except ctrl, which takes lane 0 alone
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  // write happens once both address and data are held
  wire        wr_go   = aw_got_ff && w_got_ff && !bvalid;
  wire [31:0] nxt_sta_hi = merge({16'h0, sta_ff[47:32]}, wd_ff, ws_ff);
  wire        wr_hit  = (aw_ff == RFF_OFS_CTRL) || (aw_ff == RFF_OFS_STA_LO) ||
                        (aw_ff == RFF_OFS_STA_HI) || (aw_ff == RFF_OFS_HASH_LO) ||
                        (aw_ff == RFF_OFS_HASH_HI) || (aw_ff == RFF_OFS_MASK_LO) ||
                        (aw_ff == RFF_OFS_MASK_HI) || (aw_ff == RFF_OFS_PAT);
  wire [31:0] nxt_pat = merge({psum_ff, poff_ff}, wd_ff, ws_ff);
  // write channel; slave accepts address and data in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      aw_ff     <= 8'h00;
      wd_ff     <= 32'h0000_0000;
      ws_ff     <= 4'h0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
    end else begin
      awready <= !aw_got_ff && !awready && awvalid;
      wready  <= !w_got_ff && !wready && wvalid;
      if (awvalid && awready) begin
        aw_got_ff <= 1'b1;
        aw_ff     <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_ff <= 1'b1;
        wd_ff    <= wdata;
        ws_ff    <= wstrb;
      end
      if (wr_go) begin
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? RFF_RESP_OK[1:0] : RFF_RESP_ERR;
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // register storage; ctrl steers the filters
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= RFF_CTRL_RST;
      sta_ff  <= 48'h0;
      hash_ff <= 64'h0;
      mask_ff <= 64'h0;
      poff_ff <= 16'h0;
      psum_ff <= 16'h0;
    end else if (wr_go) begin
      case (aw_ff)
        RFF_OFS_CTRL:    ctrl_ff <= ws_ff[0] ? wd_ff[7:0] : ctrl_ff;
        RFF_OFS_STA_LO:  sta_ff[31:0]  <= merge(sta_ff[31:0], wd_ff, ws_ff);
        RFF_OFS_STA_HI:  sta_ff[47:32] <= nxt_sta_hi[15:0];
        RFF_OFS_HASH_LO: hash_ff[31:0]  <= merge(hash_ff[31:0], wd_ff, ws_ff);
        RFF_OFS_HASH_HI: hash_ff[63:32] <= merge(hash_ff[63:32], wd_ff, ws_ff);
        RFF_OFS_MASK_LO: mask_ff[31:0]  <= merge(mask_ff[31:0], wd_ff, ws_ff);
        RFF_OFS_MASK_HI: mask_ff[63:32] <= merge(mask_ff[63:32], wd_ff, ws_ff);
        RFF_OFS_PAT: begin
          poff_ff <= nxt_pat[15:0];
          psum_ff <= nxt_pat[31:16];
        end
        default: ;
      endcase
    end
  end
  // read channel: one-cycle decode, unmapped answers slverr
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (araddr)
      RFF_OFS_CTRL:    rd_mux = {24'h0, ctrl_ff};
      RFF_OFS_STA_LO:  rd_mux = sta_ff[31:0];
      RFF_OFS_STA_HI:  rd_mux = {16'h0, sta_ff[47:32]};
      RFF_OFS_HASH_LO: rd_mux = hash_ff[31:0];
      RFF_OFS_HASH_HI: rd_mux = hash_ff[63:32];
      RFF_OFS_MASK_LO: rd_mux = mask_ff[31:0];
      RFF_OFS_MASK_HI: rd_mux = mask_ff[63:32];
      RFF_OFS_PAT:     rd_mux = {psum_ff, poff_ff};
      RFF_OFS_STATUS:  rd_mux = {24'h0, last_ff};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'h0;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_mux;
        rresp  <= rd_hit ? RFF_RESP_OK[1:0] : RFF_RESP_ERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // frame side
  // ---------------------------------------------------------------
  logic [15:0] pos_ff;       // byte index from destination start
  logic        da_ff;        // destination still matches station address
  logic        bc_ff;        // destination all ones so far
  logic        mc_ff;        // group bit of first byte
  logic [31:0] crc_ff;
  logic [16:0] sum_ff;       // one's complement accumulator
  logic [7:0]  hi_ff;        // pending high byte of a word
  logic        odd_ff;       // high byte pending
  logic [6:0]  wake_ff;      // wake-up sequence progress
  logic        wake_hit_ff;
  // crc over one byte, lsb first per ethernet
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ RFF_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_byte
  // one's complement add with end-around carry
  function automatic logic [16:0] oc_add(input logic [16:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a[15:0]} + {1'b0, b} + {16'h0, a[16]};
    return s;
  endfunction : oc_add
  wire [15:0] off_rel  = pos_ff - poff_ff;                            // RQ11
  wire        in_win   = (pos_ff >= poff_ff) && (off_rel < 16'(RFF_WIN_LEN));
  wire        sel_byte = in_win && mask_ff[off_rel[5:0]];            // RQ12
  wire [7:0]  sta_byte = sta_ff[8*(5 - (pos_ff < 16'(RFF_DA_LEN) ? pos_ff[2:0] : 3'h0)) +: 8];
  wire        in_da    = pos_ff < 16'(RFF_DA_LEN);
  wire [2:0]  wk_adr   = (wake_ff >= 7'(RFF_WAKE_SYNC)) ? 3'(((wake_ff - 7'(RFF_WAKE_SYNC)) % 7'd6)) : 3'h0;
  wire [7:0]  wk_exp   = (wake_ff < 7'(RFF_WAKE_SYNC)) ? 8'hff : sta_ff[8*(5 - wk_adr) +: 8];
  localparam logic [6:0] WK_DONE = 7'(RFF_WAKE_SYNC + RFF_WAKE_REPS * RFF_DA_LEN);
  // the closing byte may still sit in the window, so it is summed before the decision
  wire        odd_cur  = sel_byte ? !odd_ff : odd_ff;
  wire [7:0]  hi_cur   = (sel_byte && !odd_ff) ? rx_data : hi_ff;
  wire [16:0] sum_cur  = (sel_byte && odd_ff) ? oc_add(sum_ff, {hi_ff, rx_data}) : sum_ff;  // RQ18
  // a surplus all-ones byte keeps the sync count instead of restarting it
  wire [6:0]  nxt_wake = (rx_data == wk_exp) ? wake_ff + 7'h1 :
                         (rx_data != 8'hff) ? 7'h0 :
                         (wake_ff == 7'(RFF_WAKE_SYNC)) ? wake_ff : 7'h1;
  // per-byte filter state
  always_ff @(posedge clk) begin
    if (rst || (rx_valid && rx_last)) begin
      pos_ff      <= 16'h0;
      da_ff       <= 1'b1;
      bc_ff       <= 1'b1;
      mc_ff       <= 1'b0;
      crc_ff      <= 32'hffff_ffff;
      sum_ff      <= 17'h0;
      hi_ff       <= 8'h0;
      odd_ff      <= 1'b0;
      wake_ff     <= 7'h0;
      wake_hit_ff <= 1'b0;
    end else if (rx_valid) begin
      pos_ff <= pos_ff + 16'h1;
      if (in_da) begin
        da_ff  <= da_ff && (rx_data == sta_byte);                    // RQ20
        bc_ff  <= bc_ff && (rx_data == 8'hff);                       // RQ6
        crc_ff <= crc_byte(crc_ff, rx_data);                         // RQ19
        mc_ff  <= (pos_ff == 16'h0) ? rx_data[0] : mc_ff;            // RQ5
      end
      odd_ff <= odd_cur;                                             // RQ13
      hi_ff  <= hi_cur;
      sum_ff <= sum_cur;
      // wake-up scan restarts on mismatch; an all-ones byte may restart sync
      if (!in_da && !wake_hit_ff) begin                              // RQ16
        wake_ff     <= (nxt_wake == WK_DONE) ? 7'h0 : nxt_wake;
        wake_hit_ff <= (nxt_wake == WK_DONE);
      end
    end
  end
  // final decision on the last byte
  wire [16:0] sum_fin  = odd_cur ? oc_add(sum_cur, {hi_cur, 8'h00}) : sum_cur;
  wire [16:0] sum_fold = oc_add({1'b0, sum_fin[15:0]}, {15'h0, sum_fin[16]});
  wire        win_fits = (32'(poff_ff) + 32'(RFF_WIN_LEN)) <= (32'(pos_ff) + 32'h1);  // RQ14
  wire        hit_pat  = win_fits && (~sum_fold[15:0] == psum_ff);  // RQ10
  wire [5:0]  hidx     = crc_ff[RFF_HASH_LSB +: 6];
  wire        hit_hash = hash_ff[hidx];                              // RQ19
  wire        hit_wake = da_ff && wake_hit_ff;                       // RQ17
  wire [7:0]  en       = ctrl_ff;
  wire [6:0]  all_en   = {en[RFF_BIT_UCAST], en[RFF_BIT_PAT], en[RFF_BIT_WAKE], en[RFF_BIT_HASH],
                          en[RFF_BIT_MCAST], en[RFF_BIT_BCAST], 1'b0};
  wire [6:0]  all_hit  = {da_ff, hit_pat, hit_wake, hit_hash, mc_ff, bc_ff, 1'b0};  // RQ4 RQ7 RQ8 RQ9
  wire        and_ok   = &(~all_en | all_hit);                       // RQ1
  wire        or_ok    = |(all_en & all_hit);                        // RQ2
  wire        comb_ok  = en[RFF_BIT_AND] ? and_ok : or_ok;
  wire        fcs_ok   = !en[RFF_BIT_FCS] || rx_fcs_ok;              // RQ3
  always_ff @(posedge clk) begin
    if (rst) begin
      verdict_valid  <= 1'b0;
      verdict_accept <= 1'b0;
      last_ff        <= 8'h0;
    end else begin
      verdict_valid <= rx_valid && rx_last;                         // RQ21
      if (rx_valid && rx_last) begin
        verdict_accept <= comb_ok && fcs_ok;
        last_ff        <= {comb_ok && fcs_ok, all_hit[6:1], rx_fcs_ok};
      end
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (rst);
  property p_one_verdict;
    @(posedge clk) disable iff (rst) (rx_valid && rx_last) |=> verdict_valid;
  endproperty
  a_one_verdict: assert property (p_one_verdict) else $error("verdict missing"); // RQ21
  property p_fcs_drop;
    (rx_valid && rx_last && en[RFF_BIT_FCS] && !rx_fcs_ok) |=> !verdict_accept;
  endproperty
  a_fcs_drop: assert property (p_fcs_drop) else $error("bad fcs accepted"); // RQ3
  property p_and_mode;
    (rx_valid && rx_last && en[RFF_BIT_AND] && en[RFF_BIT_BCAST] && !bc_ff) |=> !verdict_accept;
  endproperty
  a_and_mode: assert property (p_and_mode) else $error("and mode accepted non-match"); // RQ1
  property p_or_mode;
    (rx_valid && rx_last && !en[RFF_BIT_AND] && !en[RFF_BIT_FCS] && en[RFF_BIT_BCAST] && bc_ff) |=> verdict_accept;
  endproperty
  a_or_mode: assert property (p_or_mode) else $error("or mode dropped match"); // RQ2
  property p_no_spurious;
    @(posedge clk) disable iff (rst) !(rx_valid && rx_last) |=> !verdict_valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("stray verdict"); // RQ21
  property p_short_frame;
    (rx_valid && rx_last && pos_ff < poff_ff + 16'(RFF_WIN_LEN - 1) && all_en == 7'h20) |=> !verdict_accept;
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("window beyond frame matched"); // RQ14
  property p_wake_da;
    (rx_valid && rx_last && !da_ff && all_en == 7'h10) |=> !verdict_accept;
  endproperty
  a_wake_da: assert property (p_wake_da) else $error("wake without address"); // RQ17
  property p_bresp_hold;
    @(posedge clk) disable iff (rst) (bvalid && !bready) |=> bvalid && $stable(bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped"); // AXI4-Lite register port, local design decision
endmodule : rff_filter
`default_nettype wire

// file: tb/rff_rx_src.sv
// Purpose: receive datapath model that feeds frame bytes
// Assumes: bytes change just after a rising edge
// Notes:   idle data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module rff_rx_src (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  output logic            rx_fcs_ok
);
  // -------------------------------------------------------------
  // idle state and frame sender
  // -------------------------------------------------------------
  initial begin
    rx_valid  = 1'b0;
    rx_data   = 8'h00;
    rx_last   = 1'b0;
    rx_fcs_ok = 1'b0;
  end
  // gap idles between bytes, never after the last, so the verdict slot stays clean
  task automatic send(input logic [7:0] b [0:127], input int n, input logic ok, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid  <= 1'b1;
      rx_data   <= b[i];
      rx_last   <= (i == n - 1);
      rx_fcs_ok <= (i == n - 1) ? ok : ~ok; // fcs flag only meaningful with the last byte
      if (i < n - 1) begin
        repeat (gap) begin
          @(posedge clk);
          rx_valid <= 1'b0;
          rx_data  <= ~b[i];
        end
      end
    end
    @(posedge clk);
    rx_valid  <= 1'b0;
    rx_data   <= ~b[n-1];
    rx_last   <= 1'b0;
    rx_fcs_ok <= ~ok;
  endtask : send
endmodule : rff_rx_src
`default_nettype wire

// file: tb/rff_filter_tb.sv
// Purpose: self-checking bench for the receive frame filter
// Assumes: axi4-lite master tasks, frame bytes from rff_rx_src
// Notes:   expected verdicts worked out from the filter settings
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module rff_filter_tb;
  import rff_pkg::*;
  localparam logic [47:0] STA = 48'h0211_2233_4455;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [1:0]  resp;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic   rx_valid, rx_last, rx_fcs_ok, verdict_valid, verdict_accept;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  rx_data;
  logic [7:0]  fr [0:127];
  int          n_errors = 0;
  int          check_count = 0;
  always #2.5 clk = ~clk;
  rff_filter uut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rx_valid, .rx_data, .rx_last, .rx_fcs_ok, .verdict_valid, .verdict_accept);
  rff_rx_src src (.clk, .rx_valid, .rx_data, .rx_last, .rx_fcs_ok);
  // -------------------------------------------------------------
  // bus tasks
  // -------------------------------------------------------------
  // valids drop only at their own handshake edge
  // waits as long as it takes; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rdr
  // -------------------------------------------------------------
  // frame helpers and end-of-test report
  // -------------------------------------------------------------
  task automatic build(input logic [47:0] da);
    for (int i = 0; i < 128; i++) fr[i] = (i < 6) ? da[47 - 8*i -: 8] : 8'(i * 5 + 3);
  endtask : build
  // selected bytes close up, odd tail padded with zero
  function automatic logic [15:0] csum(input logic [63:0] m, input int ofs);
    int s = 0;
    logic [7:0] hi = 8'h00;
    bit odd = 0;
    for (int i = 0; i < 64; i++) begin
      if (m[i]) begin
        if (odd) s += {hi, fr[ofs+i]};
        else hi = fr[ofs+i];
        odd = !odd;
      end
    end
    if (odd) s += {hi, 8'h00};
    while (s > 32'hffff) s = (s & 32'hffff) + (s >> 16);
    return ~s[15:0];
  endfunction : csum
  // gap varies with length so both prompt and slow feeding occur
  task automatic frame(input int n, input logic ok, input logic exp);
    int k;
    src.send(fr, n, ok, n % 3);
    #1;
    for (k = 0; k < 20 && verdict_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK("verdict_valid", 1'b1, verdict_valid)
    `CHK("verdict_accept", exp, verdict_accept)
  endtask : frame
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdr(RFF_OFS_CTRL);
    `CHK("ctrl reset", {24'h0, RFF_CTRL_RST}, rd)
    rdr(8'h24);
    `CHK("unmapped rresp", RFF_RESP_ERR, resp)
    `CHK("unmapped rdata", 32'h0, rd)
    wr(8'h24, 32'hffff_ffff);
    `CHK("unmapped bresp", RFF_RESP_ERR, resp)
    wr(RFF_OFS_STA_HI, 32'h0000_0211);
    wr(RFF_OFS_STA_LO, 32'h2233_4455);
    `CHK("write bresp", 2'h0, resp)
    build(STA);
    frame(64, 1'b1, 1'b1);
    rdr(RFF_OFS_STATUS);
    `CHK("status", 32'h0000_00c1, rd)
    frame(64, 1'b0, 1'b0);
    fr[5] = 8'h54;
    frame(64, 1'b1, 1'b0);
    build(48'hffff_ffff_ffff);
    frame(64, 1'b1, 1'b1);
    build(48'h0300_0000_0001);
    frame(64, 1'b1, 1'b0);
    wr(RFF_OFS_CTRL, 32'h0000_0002);
    rdr(RFF_OFS_CTRL);
    `CHK("ctrl rw", 32'h0000_0002, rd)
    frame(64, 1'b0, 1'b1);
    wr(RFF_OFS_CTRL, 32'h0000_00c1);
    build(48'hffff_ffff_ffff);
    frame(64, 1'b1, 1'b0);
    wr(RFF_OFS_CTRL, 32'h0000_00c2);
    build(48'h0100_0000_012c);
    frame(64, 1'b1, 1'b0);
    wr(RFF_OFS_CTRL, 32'h0000_0004);
    wr(RFF_OFS_HASH_HI, 32'h0010_0000);
    frame(64, 1'b1, 1'b1);
    wr(RFF_OFS_HASH_HI, 32'h0);
    frame(64, 1'b1, 1'b0);
    wr(RFF_OFS_CTRL, 32'h0000_0010);
    wr(RFF_OFS_MASK_LO, 32'h0000_0540);
    build(48'h0a0b_0c0d_0e0f);
    wr(RFF_OFS_PAT, {csum(64'h540, 0), 16'h0000});
    frame(64, 1'b1, 1'b1);
    fr[7] = ~fr[7];
    frame(64, 1'b1, 1'b1);
    fr[8] = ~fr[8];
    frame(64, 1'b1, 1'b0);
    wr(RFF_OFS_PAT, {csum(64'h540, 2), 16'h0002});
    frame(66, 1'b1, 1'b1);
    wr(RFF_OFS_MASK_LO, 32'h0);
    wr(RFF_OFS_PAT, 32'hffff_0002);
    frame(65, 1'b1, 1'b0);
    frame(66, 1'b1, 1'b1);
    wr(RFF_OFS_CTRL, 32'h0000_0008);
    build(STA);
    for (int i = 0; i < 6; i++) fr[20+i] = 8'hff;
    for (int i = 0; i < 96; i++) fr[26+i] = STA[47 - 8*(i % 6) -: 8];
    frame(126, 1'b1, 1'b1);
    fr[0] = 8'h03;
    frame(126, 1'b1, 1'b0);
    fr[0] = 8'h02;
    fr[121] = 8'h00;
    frame(126, 1'b1, 1'b0);
    // mid-run reset must bring the control word back to its reset value
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdr(RFF_OFS_CTRL);
    `CHK("ctrl after reset", {24'h0, RFF_CTRL_RST}, rd)
    test_done;
  end
  // hang guard, far above the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    test_done;
  end
endmodule : rff_filter_tb
`undef CHK
`default_nettype wire
